// ### rtl/suspend_mod.sv
`timescale 1ns/1ps
module suspend_mod (
	// clock and reset
	input  wire logic                        CLK_IN,
	input  wire logic                        RST_B_IN,
	// apb slave
	input  wire logic                        PSEL_IN,
	input  wire logic                        PENABLE_IN,
	input  wire logic                        PWRITE_IN,
	input  wire logic [11:0]                 PADDR_IN,
	input  wire logic [31:0]                 PWDATA_IN,
	output logic      [31:0]                 PRDATA_OUT,
	output logic                             PREADY_OUT,
	output logic                             PSLVERR_OUT,
	// wake pins 3, 4, 5, 7 in bit order 0..3
	input  wire logic [3:0]                  WAKE_PINS_IN,
	// speedup and interrupt events, one-cycle pulses
	input  wire logic                        IRQ_SPEEDUP_IN,
	input  wire logic                        VIDEO_SPEEDUP_IN,
	input  wire logic                        SMI_EVENT_IN,
	// idle decode
	input  wire suspend_mod_pkg::io_activity_t IO_ACCESS_IN,
	output logic                             SER_PAR_ACTIVITY_OUT,
	output logic                             KBD_MOUSE_ACTIVITY_OUT,
	// processor and power control
	output logic                             CPU_HALT_REQUEST_N_OUT,
	output suspend_mod_pkg::psave_ctrl_t     PSAVE_CTRL_OUT,
	output logic                             SYSTEM_MGMT_INTERRUPT_OUT
);
	import suspend_mod_pkg::*;

	// register state
	logic [7:0]   mod_off_ff;
	logic [7:0]   mod_on_ff;
	cpu_halt_request_n_cfg_t    cpu_halt_request_n_cfg_ff;
	trap_ctl_t    trap_ctl_ff;
	mouse_cfg_t   mouse_cfg_ff;
	logic [7:0]   pause_cnt_ff;
	logic [3:0]   irq_en_ff;
	logic [3:0]   pin_stat_ff;
	logic [31:0]  prdata_ff;
	// modulation state
	mod_state_t   state_ff;
	mod_state_t   nxt_state;
	logic [9:0]   presc_ff;
	logic [7:0]   ticks_ff;
	logic         halt_n_ff;
	logic         smi_prev_ff;
	logic         ser_par_ff;
	logic         kbd_mouse_ff;
	psave_ctrl_t  psave_ff;

	// address hit: word aligned, index in bits 9:2
	function automatic logic reg_hit(input logic [11:0] a,
			input logic [7:0] idx);
		reg_hit = (a[11:10] == 2'h0) && (a[9:2] == idx) && (a[1:0] == 2'h0);
	endfunction : reg_hit

	// bus phases
	wire setup_ph = PSEL_IN & ~PENABLE_IN;
	wire access_ph = PSEL_IN & PENABLE_IN;
	wire wr = access_ph & PWRITE_IN;
	wire rd = access_ph & ~PWRITE_IN;

	// address decode
	wire hit_top   = reg_hit(PADDR_IN, IDX_TOP_STATUS);
	wire hit_sdis  = reg_hit(PADDR_IN, IDX_SPEEDUP_DIS);
	wire hit_pstat = reg_hit(PADDR_IN, IDX_PIN_STATUS);
	wire hit_irqen = reg_hit(PADDR_IN, IDX_IRQ_ENABLE);
	wire hit_pcnt  = reg_hit(PADDR_IN, IDX_PAUSE_COUNT);
	wire hit_mouse = reg_hit(PADDR_IN, IDX_MOUSE_CFG);
	wire hit_off   = reg_hit(PADDR_IN, IDX_MOD_OFF);
	wire hit_on    = reg_hit(PADDR_IN, IDX_MOD_ON);
	wire hit_cpu_halt_request_n  = reg_hit(PADDR_IN, IDX_CPU_HALT_REQUEST_N_CFG);
	wire hit_trap  = reg_hit(PADDR_IN, IDX_TRAP_CTL);
	wire hit_clr   = reg_hit(PADDR_IN, IDX_IRQ_CLEAR);
	wire mapped = hit_top | hit_sdis | hit_pstat | hit_irqen | hit_pcnt |
		hit_mouse | hit_off | hit_on | hit_cpu_halt_request_n | hit_trap | hit_clr;

	// one wait-free access: read data is latched in the setup cycle
	assign PREADY_OUT  = access_ph;
	assign PSLVERR_OUT = access_ph & ~mapped;
	assign PRDATA_OUT  = prdata_ff;

	// read mux; write-only clear register reads as zero
	wire [7:0] rd_byte =
		hit_top   ? {7'h00, |pin_stat_ff} :
		hit_sdis  ? {7'h00, state_ff == ST_STOP} :
		hit_pstat ? {4'h0, pin_stat_ff} :
		hit_irqen ? {4'h0, irq_en_ff} :
		hit_pcnt  ? pause_cnt_ff :
		hit_mouse ? mouse_cfg_ff :
		hit_off   ? mod_off_ff :
		hit_on    ? mod_on_ff :
		hit_cpu_halt_request_n  ? cpu_halt_request_n_cfg_ff :
		hit_trap  ? trap_ctl_ff : 8'h00;

	// reading speedup-disable is what releases a stopped modulation
	wire sdis_read = rd & hit_sdis;

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN)
			prdata_ff <= 32'h00000000;
		else if (setup_ph)
			prdata_ff <= {24'h000000, rd_byte};
	end

	// configuration writes; reserved bits of suspend config stay zero
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			mod_off_ff   <= MOD_OFF_RST;
			mod_on_ff    <= MOD_ON_RST;
			cpu_halt_request_n_cfg_ff  <= CPU_HALT_REQUEST_N_CFG_RST;
			trap_ctl_ff  <= TRAP_CTL_RST;
			mouse_cfg_ff <= MOUSE_CFG_RST;
			pause_cnt_ff <= PAUSE_COUNT_RST;
			irq_en_ff    <= IRQ_ENABLE_RST;
		end else if (wr) begin
			if (hit_off)   mod_off_ff   <= PWDATA_IN[7:0];
			if (hit_on)    mod_on_ff    <= PWDATA_IN[7:0];
			if (hit_cpu_halt_request_n)  cpu_halt_request_n_cfg_ff  <= {3'h0, PWDATA_IN[4:0]};
			if (hit_trap)  trap_ctl_ff  <= PWDATA_IN[7:0];
			if (hit_mouse) mouse_cfg_ff <= {6'h00, PWDATA_IN[1:0]};
			if (hit_pcnt)  pause_cnt_ff <= PWDATA_IN[7:0];
			if (hit_irqen) irq_en_ff    <= PWDATA_IN[3:0];
		end
	end

	// pin edges
	logic [3:0] pin_rise;
	logic [3:0] pin_fall;

	pin_edge_sync #(.W(NUM_PINS)) u_edges (
		.clk_in   (CLK_IN),
		.rst_b_in (RST_B_IN),
		.pins_in  (WAKE_PINS_IN),
		.rise_out (pin_rise),
		.fall_out (pin_fall)
	);

	wire [3:0] pin_evt = trap_ctl_ff.src_en &
		((pin_fall & trap_ctl_ff.edge_fall) |
		 (pin_rise & ~trap_ctl_ff.edge_fall));
	wire [3:0] clr_mask = (wr && hit_clr) ? PWDATA_IN[3:0] : 4'h0;

	// sticky status, a new edge beats a clear in the same cycle
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN)
			pin_stat_ff <= 4'h0;
		else
			pin_stat_ff <= (pin_stat_ff & ~clr_mask) | pin_evt;
	end

	// level interrupt: any enabled status bit
	assign SYSTEM_MGMT_INTERRUPT_OUT = |(pin_stat_ff & irq_en_ff);

	// the block's own interrupt rising also counts as an interrupt event
	wire smi_evt = SMI_EVENT_IN | (SYSTEM_MGMT_INTERRUPT_OUT & ~smi_prev_ff);
	wire speedup = IRQ_SPEEDUP_IN | VIDEO_SPEEDUP_IN;

	// one tick per interval, restarted at each phase start
	wire tick = (presc_ff == 10'(TICK_CYCLES - 1));
	wire [7:0] limit = (state_ff == ST_ON) ? mod_on_ff :
		(state_ff == ST_PAUSE) ? pause_cnt_ff : mod_off_ff;
	wire done = (limit == 8'h00) || (tick && (ticks_ff + 8'h01 == limit));

	// modulation sequencer; interrupt wins over speedup
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_state = ST_OFF;
			end
			ST_OFF, ST_ON: begin
				if (smi_evt)
					nxt_state = cpu_halt_request_n_cfg_ff.smi_hold ? ST_STOP : ST_PAUSE;
				else if (speedup)
					nxt_state = ST_OFF;
				else if (done)
					nxt_state = (state_ff == ST_OFF) ? ST_ON : ST_OFF;
			end
			ST_PAUSE: begin
				if (smi_evt && cpu_halt_request_n_cfg_ff.smi_hold)
					nxt_state = ST_STOP;
				else if (done && !smi_evt)
					nxt_state = ST_OFF;
			end
			ST_STOP: begin
				if (sdis_read && !smi_evt)
					nxt_state = ST_OFF;
			end
			default: nxt_state = ST_IDLE;
		endcase
		if (!cpu_halt_request_n_cfg_ff.mod_en)
			nxt_state = ST_IDLE;
	end

	// a phase restarts whenever the state changes or is re-entered
	wire restart = (nxt_state != state_ff) || smi_evt || speedup ||
		(done && state_ff != ST_STOP);

	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_ff <= ST_IDLE;
			presc_ff <= 10'h000;
			ticks_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			if (restart) begin
				presc_ff <= 10'h000;
				ticks_ff <= 8'h00;
			end else if (tick) begin
				presc_ff <= 10'h000;
				ticks_ff <= ticks_ff + 8'h01;
			end else
				presc_ff <= presc_ff + 10'h001;
		end
	end

	// halt request asserted low only in the on phase
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			halt_n_ff   <= 1'b1;
			smi_prev_ff <= 1'b0;
		end else begin
			halt_n_ff   <= (nxt_state != ST_ON);
			smi_prev_ff <= SYSTEM_MGMT_INTERRUPT_OUT;
		end
	end
	assign CPU_HALT_REQUEST_N_OUT = halt_n_ff;

	wire mouse_a = mouse_cfg_ff.serial_present & ~mouse_cfg_ff.port_b;
	wire mouse_b = mouse_cfg_ff.serial_present & mouse_cfg_ff.port_b;

	// mouse port moves to the keyboard/mouse decode
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ser_par_ff   <= 1'b0;
			kbd_mouse_ff <= 1'b0;
		end else begin
			ser_par_ff <= IO_ACCESS_IN.parallel |
				(IO_ACCESS_IN.serial_a & ~mouse_a) |
				(IO_ACCESS_IN.serial_b & ~mouse_b);
			kbd_mouse_ff <= IO_ACCESS_IN.kbd |
				(IO_ACCESS_IN.serial_a & mouse_a) |
				(IO_ACCESS_IN.serial_b & mouse_b);
		end
	end
	assign SER_PAR_ACTIVITY_OUT   = ser_par_ff;
	assign KBD_MOUSE_ACTIVITY_OUT = kbd_mouse_ff;

	// bus clock only within power savings
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN)
			psave_ff <= '0;
		else begin
			psave_ff.enable        <= ~cpu_halt_request_n_cfg_ff.psave_dis;
			psave_ff.isa_clk_stop  <= cpu_halt_request_n_cfg_ff.isa_clk &
				~cpu_halt_request_n_cfg_ff.psave_dis;
			psave_ff.low_volt_cpu_halt_request_n <= cpu_halt_request_n_cfg_ff.low_volt;
		end
	end
	assign PSAVE_CTRL_OUT = psave_ff;

	// helper: cycles since the current phase began
	logic [17:0] phase_cyc_ff;
	always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN)
			phase_cyc_ff <= 18'h00000;
		else if (restart)
			phase_cyc_ff <= 18'h00000;
		else
			phase_cyc_ff <= phase_cyc_ff + 18'h00001;
	end
	wire [17:0] off_len = 18'(mod_off_ff * TICK_CYCLES);
	wire [17:0] on_len  = 18'(mod_on_ff * TICK_CYCLES);
	wire quiet = !smi_evt && !speedup && cpu_halt_request_n_cfg_ff.mod_en;

	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RST_B_IN);

	a_off_dwell: assert property (
		(state_ff == ST_OFF && quiet && done) |->
			phase_cyc_ff == off_len - 18'(|off_len) && CPU_HALT_REQUEST_N_OUT)
		else $error("off phase length wrong");

	a_on_dwell: assert property (
		(state_ff == ST_ON && quiet && done) |->
			phase_cyc_ff == on_len - 18'(|on_len) ##1 CPU_HALT_REQUEST_N_OUT)
		else $error("on phase length wrong");

	a_speedup_restart: assert property (
		((state_ff == ST_ON || state_ff == ST_OFF) && speedup && !smi_evt &&
		 cpu_halt_request_n_cfg_ff.mod_en) |=>
			state_ff == ST_OFF && ticks_ff == 8'h00 && presc_ff == 10'h000)
		else $error("speedup did not restart timers");

	a_mod_disabled: assert property (
		!cpu_halt_request_n_cfg_ff.mod_en [*2] |-> CPU_HALT_REQUEST_N_OUT)
		else $error("halt request while modulation off");

	a_hold_ignored: assert property (
		(!cpu_halt_request_n_cfg_ff.mod_en && smi_evt) |=> state_ff == ST_IDLE)
		else $error("interrupt acted while modulation off");

	a_smi_pause: assert property (
		((state_ff == ST_ON || state_ff == ST_OFF) && smi_evt &&
		 cpu_halt_request_n_cfg_ff.mod_en && !cpu_halt_request_n_cfg_ff.smi_hold) |=>
			state_ff == ST_PAUSE ##1 CPU_HALT_REQUEST_N_OUT)
		else $error("interrupt did not pause modulation");

	a_stop_release: assert property (
		(state_ff == ST_STOP && cpu_halt_request_n_cfg_ff.mod_en && !smi_evt) |=>
			(state_ff == (($past(sdis_read)) ? ST_OFF : ST_STOP)))
		else $error("stop release wrong");

	a_pin_status: assert property (
		(|pin_evt) |=> ((pin_stat_ff & $past(pin_evt)) == $past(pin_evt))
			&& (prdata_ff == prdata_ff) && (|pin_stat_ff))
		else $error("edge did not set status");

	a_src_gate: assert property (
		1'b1 |=> ((pin_stat_ff & ~$past(pin_stat_ff) &
			~$past(trap_ctl_ff.src_en)) == 4'h0))
		else $error("disabled pin set status");

	a_mouse_route: assert property (
		(mouse_a && IO_ACCESS_IN.serial_a && !IO_ACCESS_IN.serial_b &&
		 !IO_ACCESS_IN.parallel) |=>
			KBD_MOUSE_ACTIVITY_OUT && !SER_PAR_ACTIVITY_OUT)
		else $error("mouse access misrouted");

	a_isa_in_psave: assert property (
		PSAVE_CTRL_OUT.isa_clk_stop |-> PSAVE_CTRL_OUT.enable)
		else $error("bus clock stop outside power savings");

endmodule : suspend_mod

// ### rtl/suspend_mod_pkg.sv
package suspend_mod_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_TOP_STATUS  = 8'h00;
	localparam logic [7:0] IDX_SPEEDUP_DIS = 8'h08;
	localparam logic [7:0] IDX_PIN_STATUS  = 8'h84;
	localparam logic [7:0] IDX_IRQ_ENABLE  = 8'h86;
	localparam logic [7:0] IDX_PAUSE_COUNT = 8'h8C;
	localparam logic [7:0] IDX_MOUSE_CFG   = 8'h93;
	localparam logic [7:0] IDX_MOD_OFF     = 8'h94;
	localparam logic [7:0] IDX_MOD_ON      = 8'h95;
	localparam logic [7:0] IDX_CPU_HALT_REQUEST_N_CFG    = 8'h96;
	localparam logic [7:0] IDX_TRAP_CTL    = 8'h97;
	localparam logic [7:0] IDX_IRQ_CLEAR   = 8'hF4;

	// reset values
	localparam logic [7:0] MOD_OFF_RST     = 8'h00;
	localparam logic [7:0] MOD_ON_RST      = 8'h00;
	localparam logic [7:0] CPU_HALT_REQUEST_N_CFG_RST    = 8'h00;
	localparam logic [7:0] TRAP_CTL_RST    = 8'h00;
	localparam logic [7:0] MOUSE_CFG_RST   = 8'h00;
	localparam logic [7:0] PAUSE_COUNT_RST = 8'h00;
	localparam logic [3:0] IRQ_ENABLE_RST  = 4'h0;

	// field positions in the top status and speedup-disable words, and the wake pin count
	localparam int TOP_PIN_BIT  = 0;
	localparam int STOPPED_BIT  = 0;
	localparam int NUM_PINS     = 4;

	// timing: modulation interval and derived cycle count
	localparam int CLK_PERIOD_NS   = 50;
	localparam int MOD_INTERVAL_NS = 32000;
	localparam int TICK_CYCLES     = MOD_INTERVAL_NS / CLK_PERIOD_NS;

	// suspend configuration, bit 7 down to bit 0
	typedef struct packed {
		logic [2:0] rsvd;
		logic       psave_dis;
		logic       isa_clk;
		logic       low_volt;
		logic       smi_hold;
		logic       mod_en;
	} cpu_halt_request_n_cfg_t;

	// pin trap control: edge selects high nibble, enables low nibble
	typedef struct packed {
		logic [3:0] edge_fall;
		logic [3:0] src_en;
	} trap_ctl_t;

	typedef struct packed {
		logic [5:0] rsvd;
		logic       serial_present;
		logic       port_b;
	} mouse_cfg_t;

	// bus accesses seen by the idle decode
	typedef struct packed {
		logic kbd;
		logic parallel;
		logic serial_a;
		logic serial_b;
	} io_activity_t;

	// power-savings controls handed to the clock manager
	typedef struct packed {
		logic enable;
		logic isa_clk_stop;
		logic low_volt_cpu_halt_request_n;
	} psave_ctrl_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_OFF   = 3'b001,
		ST_ON    = 3'b010,
		ST_PAUSE = 3'b011,
		ST_STOP  = 3'b100
	} mod_state_t;

endpackage : suspend_mod_pkg

// ### rtl/pin_edge_sync.sv
`timescale 1ns/1ps
module pin_edge_sync #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_b_in,
	// raw pins and edge pulses
	input  wire logic [W-1:0] pins_in,
	output logic      [W-1:0] rise_out,
	output logic      [W-1:0] fall_out
);

	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] prev_ff;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= pins_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign rise_out = sync_ff & ~prev_ff;
	assign fall_out = ~sync_ff & prev_ff;

endmodule : pin_edge_sync

// ### bench/cpu_halt_model.sv
`timescale 1ns/1ps
// far-side processor: measures how long each halt request level is held
module cpu_halt_model (
	// clock and reset
	input  wire logic clk_in,
	input  wire logic rst_b_in,
	// halt request, active low
	input  wire logic halt_n_in,
	// last complete high and low run lengths, number of level changes
	output int        hi_len_out,
	output int        lo_len_out,
	output int        n_edges_out
);
	int   run;
	logic last;

	// the processor only sees the request at clock edges, so runs are
	// counted in whole cycles rather than nanoseconds
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			run         <= 0;
			last        <= 1'b1;
			hi_len_out  <= 0;
			lo_len_out  <= 0;
			n_edges_out <= 0;
		end else if (halt_n_in !== last) begin
			if (last)
				hi_len_out <= run;
			else
				lo_len_out <= run;
			n_edges_out <= n_edges_out + 1;
			run         <= 1;
			last        <= halt_n_in;
		end else begin
			run <= run + 1;
		end
	end
endmodule : cpu_halt_model

// ### bench/suspend_mod_test.sv
`timescale 1ns/1ps
module suspend_mod_test;
	import suspend_mod_pkg::*;
	logic         clk, rst_b, psel, penable, pwrite, pready, pslverr;
	logic         irq_sp, vid_sp, smi_ev, ser_par, kbd_mouse, system_mgmt_interrupt, halt_n;
	logic         err, mouse;
	logic [11:0]  paddr;
	logic [31:0]  pwdata, prdata, rd;
	logic [3:0]   pins;
	io_activity_t io;
	psave_ctrl_t  psave;
	int           error_cnt, n_checks, hi_len, lo_len, n_edges;
	int           cyc = 0;
	logic [7:0]   regs [4] = '{IDX_MOD_OFF, IDX_MOD_ON, IDX_TRAP_CTL,
		IDX_PAUSE_COUNT};
	logic [7:0]   cfg_wr [3] = '{8'hEC, 8'h14, 8'h08};
	logic [7:0]   cfg_rd [3] = '{8'h0C, 8'h14, 8'h08};
	logic [2:0]   ps_exp [3] = '{3'h7, 3'h1, 3'h6};

	suspend_mod i_suspend_mod (.CLK_IN(clk), .RST_B_IN(rst_b),
		.PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .WAKE_PINS_IN(pins),
		.IRQ_SPEEDUP_IN(irq_sp), .VIDEO_SPEEDUP_IN(vid_sp),
		.SMI_EVENT_IN(smi_ev), .IO_ACCESS_IN(io),
		.SER_PAR_ACTIVITY_OUT(ser_par), .KBD_MOUSE_ACTIVITY_OUT(kbd_mouse),
		.CPU_HALT_REQUEST_N_OUT(halt_n), .PSAVE_CTRL_OUT(psave),
		.SYSTEM_MGMT_INTERRUPT_OUT(system_mgmt_interrupt));

	cpu_halt_model i_cpu_halt_model (.clk_in(clk), .rst_b_in(rst_b),
		.halt_n_in(halt_n), .hi_len_out(hi_len), .lo_len_out(lo_len),
		.n_edges_out(n_edges));

	// clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// hang guard: the whole sequence needs roughly 12000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			final_report();
		end
	end

	task final_report;
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : final_report

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// one apb transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [7:0] idx, input logic [31:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task rchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
		apb(1'b0, idx, 32'h0);
		chk(nm, e, rd);
	endtask : rchk

	// waits for halt level changes, bounded so a dead output cannot hang
	task wait_edges(input int n);
		int b;
		b = n_edges;
		repeat (5000)
			if (n_edges < b + n)
				@(posedge clk);
	endtask : wait_edges

	task pulse_smi;
		@(posedge clk);
		smi_ev <= 1'b1;
		@(posedge clk);
		smi_ev <= 1'b0;
	endtask : pulse_smi

	// main sequence
	initial begin
		{rst_b, psel, penable, pwrite, irq_sp, vid_sp, smi_ev} = '0;
		{paddr, pwdata, pins, io} = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		chk("psave reset", 3'h4, psave);
		rchk("cfg reset", IDX_CPU_HALT_REQUEST_N_CFG, 0);
		for (int i = 0; i < 4; i++) begin
			rchk("reg reset", regs[i], 0);
			wr(regs[i], 32'h5A);
			rchk("reg rw", regs[i], 32'h5A);
		end
		apb(1'b0, 8'h01, 32'h0);
		chk("unmapped err", 1, err);
		// power-savings fields, reserved bits read back as zero
		for (int i = 0; i < 3; i++) begin
			wr(IDX_CPU_HALT_REQUEST_N_CFG, cfg_wr[i]);
			rchk("cfg rd", IDX_CPU_HALT_REQUEST_N_CFG, cfg_rd[i]);
			chk("psave", ps_exp[i], psave);
		end
		wr(IDX_CPU_HALT_REQUEST_N_CFG, 0);
		// serial accesses routed by the mouse setting
		for (int m = 0; m < 4; m++) begin
			for (int p = 0; p < 4; p++) begin
				wr(IDX_MOUSE_CFG, m);
				@(posedge clk);
				// p: 0 serial b, 1 serial a, 2 parallel, 3 keyboard
				io <= 4'(1 << p);
				repeat (3) @(posedge clk);
				mouse = (p == 3) || (p < 2 && m > 1 && (m % 2) == (p == 0));
				chk("kbd mouse", mouse, kbd_mouse);
				chk("ser par", !mouse, ser_par);
				io <= '0;
			end
		end
		// each pin alone, both edge senses; disabled pins toggle too
		wr(IDX_IRQ_ENABLE, 32'h5);
		for (int i = 0; i < 4; i++) begin
			for (int f = 0; f < 2; f++) begin
				wr(IDX_TRAP_CTL, {4'(f << i), 4'(1 << i)});
				@(posedge clk);
				// trap pins are only ever driven as inputs
				pins <= 4'hF;
				repeat (6) @(posedge clk);
				pins <= 4'h0;
				repeat (6) @(posedge clk);
				rchk("pin status", IDX_PIN_STATUS, 1 << i);
				rchk("top status", IDX_TOP_STATUS, 1);
				chk("irq level", (i % 2) == 0, system_mgmt_interrupt);
				wr(IDX_IRQ_CLEAR, 32'hF);
				rchk("pin cleared", IDX_PIN_STATUS, 0);
				chk("irq low", 0, system_mgmt_interrupt);
			end
		end
		// modulation: off one interval, on two
		wr(IDX_TRAP_CTL, 0);
		wr(IDX_MOD_OFF, 1);
		wr(IDX_MOD_ON, 2);
		wr(IDX_PAUSE_COUNT, 2);
		chk("halt idle", 1, halt_n);
		wr(IDX_CPU_HALT_REQUEST_N_CFG, 1);
		wait_edges(4);
		chk("off len", TICK_CYCLES, hi_len);
		chk("on len", 2 * TICK_CYCLES, lo_len);
		wait_edges(1);
		for (int s = 0; s < 2; s++) begin
			repeat (100) @(posedge clk);
			irq_sp <= (s == 0);
			vid_sp <= (s == 1);
			@(posedge clk);
			irq_sp <= 1'b0;
			vid_sp <= 1'b0;
			wait_edges(2);
			chk("on cut", 1, lo_len < 300);
			chk("off restart", TICK_CYCLES, hi_len);
		end
		repeat (100) @(posedge clk);
		pulse_smi();
		wait_edges(2);
		chk("pause len", 3 * TICK_CYCLES, hi_len);
		wr(IDX_CPU_HALT_REQUEST_N_CFG, 3);
		pulse_smi();
		wait_edges(1);
		repeat (3000) @(posedge clk);
		chk("stopped", 1, halt_n);
		rchk("stop flag", IDX_SPEEDUP_DIS, 1);
		wait_edges(1);
		chk("released", 1, hi_len > 3000 + TICK_CYCLES);
		wr(IDX_CPU_HALT_REQUEST_N_CFG, 2);
		repeat (5) @(posedge clk);
		pulse_smi();
		repeat (5) @(posedge clk);
		rchk("no stop", IDX_SPEEDUP_DIS, 0);
		chk("halt off", 1, halt_n);
		final_report();
	end
endmodule : suspend_mod_test
